// *** core/ecl_loader.sv ***
// Configuration loader: strap decode, EEPROM image read, attribute decode
`timescale 1ns/1ps
`default_nettype none

module ecl_loader (
   input  wire logic                  sys_clk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  internal_code_select_i,
   input  wire logic [3:0]            strap_option_i,
   input  wire logic                  density_sense_in_i,
   input  wire logic                  drive_ready_in_i,
   input  wire logic                  disk_change_in_i,
   input  wire logic                  eep_do_i,
   input  wire logic                  motor_req_i,
   input  wire logic                  step_req_i,
   input  wire logic [7:0]            rd_addr_i,
   output logic                       use_external_code_o,
   output ecl_pkg::ecl_eep_type       eep_o,
   output logic                       config_ready_o,
   output logic [7:0]                 rd_data_o,
   output logic [7:0]                 inq_data_o,
   output ecl_pkg::ecl_attr_type      attr_o,
   output logic                       high_density_o,
   output logic                       motor_on_o,
   output logic                       step_ok_o,
   output logic                       disk_changed_o
);
   typedef enum logic [2:0] {ECL_IDLE, ECL_SHIFT, ECL_DONE, ECL_EXT} ecl_state_type;

   ecl_state_type state;
   logic [1:0]  sync_rom, sync_dens, sync_rdy, sync_chg, sync_do;
   logic [7:0]  strap_a;
   logic [1:0]  strap_wait;
   logic [3:0]  strap_cap;
   logic        strap_taken;
   logic [3:0]  div_cnt;
   logic [7:0]  bit_cnt;
   logic [7:0]  byte_idx;
   logic [7:0]  shreg;
   logic [7:0]  image [0:ecl_pkg::IMAGE_LEN-1];
   logic [31:0] attr_word;
   logic        wr_byte;
   logic        ready_seen;

   // Index bound check used by the image writer and the host reader
   function automatic logic in_image(input logic [7:0] a);
      return a < 8'(ecl_pkg::IMAGE_LEN);
   endfunction

   // Two-stage synchronisers for pins
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_rom  <= 2'h3;
         sync_dens <= 2'h0;
         sync_rdy  <= 2'h0;
         sync_chg  <= 2'h0;
         sync_do   <= 2'h0;
         strap_a   <= 8'h00;
      end else begin
         sync_rom  <= {sync_rom[0], internal_code_select_i};
         sync_dens <= {sync_dens[0], density_sense_in_i};
         sync_rdy  <= {sync_rdy[0], drive_ready_in_i};
         sync_chg  <= {sync_chg[0], disk_change_in_i};
         sync_do   <= {sync_do[0], eep_do_i};
         strap_a   <= {strap_a[3:0], strap_option_i};
      end
   end

   // Strap capture once after reset release
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strap_cap   <= 4'h0;
         strap_taken <= 1'b0;
         strap_wait  <= 2'h0;
      end else if (!strap_taken) begin
         // Wait until the option pins have passed both synchroniser stages
         if (strap_wait == ecl_pkg::STRAP_SETTLE) begin
            strap_cap   <= strap_a[7:4];
            strap_taken <= 1'b1;
         end else begin
            strap_wait <= strap_wait + 2'h1;
         end
      end
   end

   // Loader sequence
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state               <= ECL_IDLE;
         use_external_code_o <= 1'b0;
         config_ready_o      <= 1'b0;
         eep_o               <= '0;
         div_cnt             <= 4'h0;
         bit_cnt             <= 8'h00;
         byte_idx            <= 8'h00;
         shreg               <= 8'h00;
         wr_byte             <= 1'b0;
      end else begin
         wr_byte <= 1'b0;
         case (state)
            ECL_IDLE: begin
               if (strap_taken) begin
                  if (!sync_rom[1]) begin
                     state               <= ECL_EXT;
                     use_external_code_o <= 1'b1;
                  end else begin
                     state    <= ECL_SHIFT;
                     eep_o.cs <= 1'b1;
                     eep_o.di <= ecl_pkg::READ_OPCODE[3'h7]; // First bit before first rise
                     bit_cnt  <= 8'h00;
                     byte_idx <= 8'h00;
                  end
               end
            end
            ECL_SHIFT: begin
               // Opcode and address out, then the image in sequential read
               if (div_cnt == ecl_pkg::SCK_HALF) begin
                  div_cnt   <= 4'h0;
                  eep_o.sck <= ~eep_o.sck;
                  if (!eep_o.sck) begin
                     // Rising clock: memory bit has stood a half period, take it
                     if (bit_cnt >= ecl_pkg::BIT_COUNT)
                        shreg <= {shreg[6:0], sync_do[1]};
                     if (bit_cnt >= ecl_pkg::BIT_COUNT && bit_cnt[2:0] == 3'h7)
                        wr_byte <= 1'b1;
                     bit_cnt <= (bit_cnt == 8'hFF) ? ecl_pkg::BIT_COUNT : bit_cnt + 8'h01;
                  end else begin
                     // Falling clock: next command bit, held over the next rise
                     if (bit_cnt < 8'h08)
                        eep_o.di <= ecl_pkg::READ_OPCODE[3'(8'h07 - bit_cnt)];
                     else
                        eep_o.di <= 1'b0;
                  end
               end else begin
                  div_cnt <= div_cnt + 4'h1;
               end
               if (wr_byte) begin
                  if (byte_idx == 8'(ecl_pkg::IMAGE_LEN - 1)) begin
                     state          <= ECL_DONE;
                     eep_o          <= '0;
                     config_ready_o <= 1'b1;
                  end
                  byte_idx <= byte_idx + 8'h01;
               end
            end
            ECL_DONE: state <= ECL_DONE;
            default:  state <= ECL_EXT;
         endcase
      end
   end

   // Image storage, bytes kept in stored order
   always_ff @(posedge sys_clk_i) begin
      if (wr_byte && state == ECL_SHIFT && in_image(byte_idx))
         image[byte_idx] <= shreg;
   end

   // Attribute word assembled most significant byte first
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         attr_word <= 32'h0000_0000;
      else if (wr_byte && state == ECL_SHIFT && byte_idx >= 8'(ecl_pkg::ATTR_OFS))
         attr_word <= {attr_word[23:0], shreg};
   end

   // Interdependent attribute decode, applied once loaded
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         attr_o <= '0;
      end else if (config_ready_o) begin
         attr_o.tape_mode <= attr_word[ecl_pkg::ATTR_TAPE_HI]
                           | attr_word[ecl_pkg::ATTR_TAPE_LO];
         // High level means double density unless a high-density marker is set
         attr_o.density_high_is_dd <= ~((attr_word[ecl_pkg::ATTR_DENS]
                                         ^ attr_word[ecl_pkg::ATTR_DENS_FLIP])
                                        | attr_word[ecl_pkg::ATTR_AFTER]
                                        | attr_word[ecl_pkg::ATTR_DENS_LOW]);
         attr_o.density_unused <= ~attr_word[ecl_pkg::ATTR_NODENS]
                                & ~attr_word[ecl_pkg::ATTR_DENS - 1];
         attr_o.ready_after_motor <= attr_word[ecl_pkg::ATTR_AFTER];
         attr_o.change_motor_off <= attr_word[ecl_pkg::ATTR_CHG_B]
                                  | (attr_word[ecl_pkg::ATTR_CHG_A]
                                     & ~attr_word[ecl_pkg::ATTR_CHG_MASK]);
      end
   end

   // Host read port for descriptors and inquiry
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_data_o  <= 8'h00;
         inq_data_o <= 8'h00;
      end else begin
         rd_data_o <= (config_ready_o && in_image(rd_addr_i)) ? image[rd_addr_i] : 8'h00;
         if (!config_ready_o || rd_addr_i >= 8'(ecl_pkg::INQ_LEN))
            inq_data_o <= 8'h00;
         else if (rd_addr_i < 8'(ecl_pkg::INQ_FIXED))
            inq_data_o <= ecl_pkg::INQ_HEAD[8'(63 - 8 * rd_addr_i[2:0]) -: 8];
         else
            inq_data_o <= image[8'(ecl_pkg::INQ_OFS) + rd_addr_i];
      end
   end

   // Drive sequencing by ready mode
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         motor_on_o     <= 1'b0;
         step_ok_o      <= 1'b0;
         ready_seen     <= 1'b0;
         high_density_o <= 1'b0;
         disk_changed_o <= 1'b0;
      end else begin
         if (sync_rdy[1])
            ready_seen <= 1'b1;
         if (!attr_o.ready_after_motor)
            motor_on_o <= motor_req_i && config_ready_o && (ready_seen || sync_rdy[1]);
         else
            motor_on_o <= motor_req_i && config_ready_o;
         step_ok_o <= config_ready_o && (!attr_o.ready_after_motor
                      || (motor_on_o && sync_rdy[1])) && step_req_i;
         high_density_o <= attr_o.density_unused ? 1'b0
                         : (sync_dens[1] ^ attr_o.density_high_is_dd
                            ^ ~strap_cap[3]);
         disk_changed_o <= sync_chg[1] && (attr_o.change_motor_off || motor_on_o);
      end
   end

   // Step only allowed with ready in after-motor mode
   a_step_ready: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      step_ok_o && attr_o.ready_after_motor |-> $past(sync_rdy[1]))
      else $error("step granted without drive ready");
   a_load_first: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !config_ready_o |-> ##1 (motor_on_o == 1'b0 || config_ready_o))
      else $error("motor before configuration loaded");
   a_ext_code: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      use_external_code_o |-> !eep_o.cs)
      else $error("eeprom selected in external code mode");
   // Host reads stay blank until the whole image is in
   a_read_gated: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !config_ready_o |=> (rd_data_o == 8'h00 && inq_data_o == 8'h00))
      else $error("host read answered before image loaded");
   // Before-motor mode never starts the motor ahead of drive ready
   a_motor_wait: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      motor_on_o && !attr_o.ready_after_motor |-> $past(ready_seen || sync_rdy[1]))
      else $error("motor started before drive ready");
   // Change flag only passes in the configured motor condition
   a_change_gate: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      disk_changed_o |-> $past(attr_o.change_motor_off || motor_on_o))
      else $error("disk change reported with motor off");
   // No density pin means density output stays low
   a_dens_unused: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      attr_o.density_unused |=> !high_density_o)
      else $error("density reported with no density pin");

endmodule
`default_nettype wire

// *** core/ecl_pkg.sv ***
// Package for the serial EEPROM configuration loader
package ecl_pkg;
   // Image layout, byte offsets and lengths
   localparam int unsigned DEVDESC_OFS  = 0;
   localparam int unsigned DEVDESC_LEN  = 18;
   localparam int unsigned LANG_OFS     = 18;
   localparam int unsigned LANG_LEN     = 4;
   localparam int unsigned STR_LEN      = 60;
   localparam int unsigned MANUF_OFS    = 22;
   localparam int unsigned PROD_OFS     = 82;
   localparam int unsigned SERIAL_OFS   = 142;
   localparam int unsigned INQ_OFS      = 202;
   localparam int unsigned INQ_LEN      = 36;
   localparam int unsigned ATTR_OFS     = 238;
   localparam int unsigned IMAGE_LEN    = 242;
   localparam int unsigned VID_LO_POS   = 9;
   localparam int unsigned PID_HI_POS   = 12;
   localparam int unsigned INQ_FIXED    = 8;
   // Fixed inquiry header, byte 0 in the top lane
   localparam logic [63:0] INQ_HEAD     = 64'h0080_0001_1F00_0000;
   // Attribute word field positions
   localparam int unsigned ATTR_TAPE_HI = 31;
   localparam int unsigned ATTR_TAPE_LO = 29;
   localparam int unsigned ATTR_DENS    = 20;
   localparam int unsigned ATTR_NODENS  = 18;
   localparam int unsigned ATTR_AFTER   = 19;
   localparam int unsigned ATTR_CHG_A   = 25;
   localparam int unsigned ATTR_CHG_B   = 26;
   // Markers that refine density and change-detect decode
   localparam int unsigned ATTR_DENS_FLIP = 30;
   localparam int unsigned ATTR_DENS_LOW  = 0;
   localparam int unsigned ATTR_CHG_MASK  = 24;
   // Clocks to wait after reset before the straps are taken
   localparam logic [1:0]  STRAP_SETTLE = 2'h2;
   // Serial clock divider terminal count, half period is SCK_HALF + 1 system clocks
   localparam logic [3:0]  SCK_HALF     = 4'h5;
   localparam logic [7:0]  READ_OPCODE  = 8'h03;
   localparam logic [7:0]  BIT_COUNT    = 8'h18;

   // Decoded drive settings
   typedef struct packed {
      logic tape_mode;
      logic density_high_is_dd;
      logic density_unused;
      logic ready_after_motor;
      logic change_motor_off;
   } ecl_attr_type;

   // Serial EEPROM pins
   typedef struct packed {
      logic cs;
      logic sck;
      logic di;
   } ecl_eep_type;
endpackage

// *** dv/ecl_eeprom_model.sv ***
// Behavioural serial configuration EEPROM on the loader's far side
`timescale 1ns/1ps
`default_nettype none
module ecl_eeprom_model (
   input  wire logic cs_i,
   input  wire logic sck_i,
   input  wire logic di_i,
   output logic      do_o
);
   logic [7:0]  mem [0:241];
   logic [23:0] cmd = 24'h000000;
   int          nbit = 0;
   logic        out_bit = 1'b0;
   // ==========
   // Command shift on rising clock, cleared by each deselect
   always @(posedge sck_i or negedge cs_i) begin
      if (!cs_i) begin
         nbit <= 0;
      end else begin
         if (nbit < 24) cmd <= {cmd[22:0], di_i};
         nbit <= nbit + 1;
      end
   end
   // Read data moves on falling clock, MSB of each byte first
   always @(negedge sck_i) begin
      if (cs_i && nbit >= 24 && cmd[23:16] == ecl_pkg::READ_OPCODE) begin
         out_bit <= mem[(int'(cmd[7:0]) + (nbit - 24) / 8) % 242][7 - (nbit - 24) % 8];
      end else begin
         out_bit <= ~out_bit; // No valid data: line toggles
      end
   end
   // Deselected line shows the inverse of the last bit
   assign do_o = cs_i ? out_bit : ~out_bit;
endmodule
`default_nettype wire

// *** dv/eeprom_config_loader_test.sv ***
// Self-checking bench for the EEPROM configuration loader
`timescale 1ns/1ps
`default_nettype none
module eeprom_config_loader_test;
   typedef struct {int kind; logic [7:0] exp;} ecl_note_type;
   localparam logic [15:0] VENDOR_ID  = 16'h1234; // Arbitrary value
   localparam logic [15:0] PRODUCT_ID = 16'h5678; // Arbitrary value
   logic                  clk = 1'b0;
   logic                  resetn = 1'b0;
   logic                  code_sel = 1'b1;
   logic [3:0]            strap = 4'h8;
   logic                  dens = 1'b0, ready = 1'b0, dchg = 1'b0;
   logic                  motor_req = 1'b0, step_req = 1'b0;
   logic [7:0]            rd_addr = 8'h00, rd_data, inq_data;
   logic                  eep_do, ext, cfg_rdy, hd, motor_on, step_ok, dchanged;
   logic                  look = 1'b0, look_d = 1'b0;
   ecl_pkg::ecl_eep_type  eep;
   ecl_pkg::ecl_attr_type attr;
   ecl_note_type          notes [$];
   ecl_note_type          nt;
   logic [7:0]            obs [0:8];
   string                 what [0:8] = '{"rd_data", "inq_data", "attr", "high_density",
      "motor_on", "step_ok", "disk_changed", "ext_code", "cfg_ready"};
   int                    seed = 32'h4a5ac0ea;
   int                    n_fail = 0, checks_done = 0;
   // ==========
   // Clock, design and far-side memory
   always #25 clk = ~clk;
   ecl_loader dut (
      .sys_clk_i(clk), .resetn_i(resetn), .internal_code_select_i(code_sel),
      .strap_option_i(strap), .density_sense_in_i(dens), .drive_ready_in_i(ready),
      .disk_change_in_i(dchg), .eep_do_i(eep_do), .motor_req_i(motor_req),
      .step_req_i(step_req), .rd_addr_i(rd_addr), .use_external_code_o(ext), .eep_o(eep),
      .config_ready_o(cfg_rdy), .rd_data_o(rd_data), .inq_data_o(inq_data), .attr_o(attr),
      .high_density_o(hd), .motor_on_o(motor_on), .step_ok_o(step_ok),
      .disk_changed_o(dchanged));
   ecl_eeprom_model rom (.cs_i(eep.cs), .sck_i(eep.sck), .di_i(eep.di), .do_o(eep_do));
   assign obs = '{rd_data, inq_data, {3'h0, attr}, {7'h0, hd}, {7'h0, motor_on},
      {7'h0, step_ok}, {7'h0, dchanged}, {7'h0, ext}, {7'h0, cfg_rdy}};
   // ==========
   // Shared tasks
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic note(input int k, input logic [7:0] e);
      notes.push_back('{k, e});
      look = 1'b1;
      tick(1);
      look = 1'b0;
      tick(1);
   endtask
   task automatic put32(input int ofs, input logic [31:0] w);
      for (int k = 0; k < 4; k++) rom.mem[ofs + k] = w[31 - 8 * k -: 8];
   endtask
   task automatic reset_dut(input logic sel);
      resetn = 1'b0;
      code_sel = sel;
      tick(8);
      resetn = 1'b1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One image load with a given attribute word, then reads and drive checks
   task automatic run_variant(input logic [31:0] word, input logic [4:0] ea, input logic [3:0] st);
      int          i;
      logic [63:0] head;
      head = ecl_pkg::INQ_HEAD;
      for (i = 0; i < 242; i++) rom.mem[i] = (i < 18) ? 8'($random(seed)) : 8'h00;
      rom.mem[0] = 8'h12;
      {rom.mem[12], rom.mem[11], rom.mem[10], rom.mem[9]} = {PRODUCT_ID, VENDOR_ID};
      put32(ecl_pkg::LANG_OFS, 32'h0403_0904);
      for (i = 0; i < 3; i++) put32(22 + 60 * i, {16'h3C03, 8'h41 + 8'($random(seed) & 15), 8'h00});
      for (i = 0; i < 36; i++) rom.mem[202 + i] = (i < 8) ? head[63 - 8 * i -: 8] : 8'h20 + 8'($random(seed) & 63);
      put32(ecl_pkg::ATTR_OFS, word);
      strap = st;
      reset_dut(1'b1);
      tick(100);
      note(8, 8'h00);
      note(0, 8'h00);
      note(7, 8'h00);
      for (i = 0; i < 30000 && cfg_rdy !== 1'b1; i++) tick(1);
      note(8, 8'h01);
      for (i = 0; i < 242; i++) begin
         rd_addr = 8'(i);
         note(0, rom.mem[i]);
      end
      for (i = 0; i < 36; i++) begin
         rd_addr = 8'(i);
         note(1, (i < 8) ? head[63 - 8 * i -: 8] : rom.mem[202 + i]);
      end
      note(2, {3'h0, ea});
      for (i = 0; i < 2; i++) begin
         dens = i[0];
         tick(6);
         if (!ea[2]) note(3, {7'h0, i[0] ^ ea[3] ^ ~st[3]});
      end
      motor_req = 1'b1;
      step_req = 1'b1;
      dchg = 1'b1;
      tick(6);
      note(4, {7'h0, ea[1]});
      note(5, {7'h0, !ea[1]});
      note(6, {7'h0, ea[1] | ea[0]});
      ready = 1'b1;
      tick(6);
      note(4, 8'h01);
      note(5, 8'h01);
      ready = 1'b0;
      motor_req = 1'b0;
      step_req = 1'b0;
      dchg = 1'b0;
   endtask
   // ==========
   // Monitor takes the oldest note when a result is due
   always @(posedge clk) begin
      if (look_d) begin
         nt = notes.pop_front();
         check(what[nt.kind], obs[nt.kind], nt.exp);
      end
      look_d = look;
   end
   // Main sequence
   initial begin
      run_variant(32'hC014_0004, 5'b11000, 4'h8);
      run_variant(32'h020C_0000, 5'b00011, 4'h0);
      run_variant(32'h0001_0000, 5'b01100, 4'h8);
      reset_dut(1'b0);
      tick(10);
      note(7, 8'h01);
      tick(4);
      tally_and_finish();
   end
   // Watchdog sized from three image loads
   initial begin
      tick(95000);
      n_fail++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
